// ==== include/tsc_cfg.svh ====
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// ==========================================================================
// Register offsets
`define TSC_ADDR_STATUS2 8'h21
`define TSC_ADDR_LCV_HI 8'h23
`define TSC_ADDR_LCV_LO 8'h24
`define TSC_ADDR_PCV_HI 8'h25
`define TSC_ADDR_PCV_LO 8'h26
`define TSC_ADDR_MASK2 8'h6f
`define TSC_ADDR_MASK1 8'h7f

// ==========================================================================
// Status two bit positions
`define TSC_B_RX_MF 7
`define TSC_B_TX_MF 6
`define TSC_B_SEC 5
`define TSC_B_RX_FULL 4
`define TSC_B_TX_EMPTY 3
`define TSC_B_MATCH 2
`define TSC_B_ABORT 1
`define TSC_B_SIG_CHG 0

// ==========================================================================
// Reset values
`define TSC_MASK_RST 8'h00
`define TSC_STATUS_RST 8'h00

// ==========================================================================
// Timing: one receive frame every 125 us
`define TSC_FRAME_US 125
`define TSC_SEC_SHORT_MS 999
`define TSC_SEC_LONG_MS 1002
`define TSC_SHORT_PERIOD_MS 42
`define TSC_MS_TO_FRAMES(ms) (((ms) * 1000) / `TSC_FRAME_US)

// ==========================================================================
// Counter widths and line code thresholds
`define TSC_LCV_W 16
`define TSC_PCV_W 12
`define TSC_MOS_W 12
`define TSC_ZERO_RUN_LONG 5'd16
`define TSC_ZERO_RUN_SHORT 5'd8
`define TSC_ABORT_ONES 4'd8

`endif

// ==== include/tsc_pkg.sv ====
package tsc_pkg;

    // ======================================================================
    // Parallel control port request
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } tsc_bus_t;

    // ======================================================================
    // Receive line events, one per received bit
    typedef struct packed {
        logic vld;
        logic zero;
        logic bpv;
        logic sub_word;
    } tsc_line_t;

    // ======================================================================
    // Receive path errors, one pulse per error
    typedef struct packed {
        logic crc_err;
        logic ft_err;
        logic fs_err;
    } tsc_path_t;

    // ======================================================================
    // Second timer phase
    typedef enum logic [2:0] {
        TSC_PH_A = 3'b001,
        TSC_PH_B = 3'b010,
        TSC_PH_C = 3'b100
    } tsc_phase_t;

endpackage

// ==== hw/tsc_err_counter.sv ====
`include "tsc_cfg.svh"

module tsc_err_counter #(
    parameter int W = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_inc,
    input wire logic i_snap,
    output logic [W-1:0] o_value
);
    import tsc_pkg::*;

    // ======================================================================
    // Accumulator with saturation and snapshot
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;
    logic at_max;

    assign at_max = &acc_r;
    assign acc_nxt = i_snap ? {{(W-1){1'b0}}, i_inc} :
                     (i_inc && !at_max) ? acc_r + W'(1) : acc_r;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc_r <= '0;
            o_value <= '0;
        end else begin
            acc_r <= acc_nxt;
            if (i_snap) begin
                o_value <= acc_r;
            end
        end
    end

    a_sat_holds: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
        at_max && !i_snap |=> at_max)
        else $error("counter left its maximum");

endmodule // tsc_err_counter

// ==== hw/tsc_status_counters.sv ====
`include "tsc_cfg.svh"

// Behaviour
// - Receive multiframe boundary sets status bit 7
// - Transmit multiframe boundary sets status bit 6
// - Second tick intervals 999, 999, 1002 ms
// - Receive link buffer full sets bit 4
// - Transmit link buffer empty sets bit 3
// - Link byte matching either pattern sets bit 2
// - Eight ones on link sets bit 1
// - Any signaling bit change sets bit 0
// - Alarm mask register at 7f
// - Event mask at 6f; one enables
// - Counters update per second or 42 ms
// - Readable counts hold previous interval
// - Counters saturate, never wrap
// - Line count 16 bits at 23/24
// - Line count content follows zero options
// - Line count runs even without sync
// - Framing select high counts CRC6 errors
// - Superframe counts Ft, optionally Fs errors
// - Path count halts while sync lost
// - Path count at 25 low nibble, 26
// - Upper nibble of 25 is other counter
module tsc_status_counters #(
    parameter int SIG_W = 24,
    parameter int SEC_SHORT_FRAMES = `TSC_MS_TO_FRAMES(`TSC_SEC_SHORT_MS),
    parameter int SEC_LONG_FRAMES = `TSC_MS_TO_FRAMES(`TSC_SEC_LONG_MS),
    parameter int SHORT_FRAMES = `TSC_MS_TO_FRAMES(`TSC_SHORT_PERIOD_MS)
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire tsc_pkg::tsc_bus_t i_bus,
    output logic [7:0] o_rdata,
    output logic o_int,
    input wire logic i_frame_tick,
    input wire logic i_rx_mf,
    input wire logic i_tx_mf,
    input wire logic i_rx_link_full,
    input wire logic i_tx_link_empty,
    input wire logic i_link_byte_vld,
    input wire logic [7:0] i_link_byte,
    input wire logic [7:0] i_link_match_pattern_a,
    input wire logic [7:0] i_link_match_pattern_b,
    input wire logic i_fdl_bit_vld,
    input wire logic i_fdl_bit,
    input wire logic i_sig_vld,
    input wire logic [SIG_W-1:0] i_sig_bits,
    input wire logic [7:0] i_alarm_status,
    input wire tsc_pkg::tsc_line_t i_line,
    input wire logic i_excess_zero_en,
    input wire logic i_rx_zero_sub_enable,
    input wire tsc_pkg::tsc_path_t i_path,
    input wire logic i_rx_framing_select,
    input wire logic i_fs_error_count_enable,
    input wire logic i_sync_loss,
    input wire logic i_counter_period_select,
    input wire logic i_mos_inc
);
    import tsc_pkg::*;

    // ======================================================================
    // Address decode
    logic sel_status2;
    logic sel_mask1;
    logic sel_mask2;
    logic wr_mask1;
    logic wr_mask2;
    logic rd_status2;

    assign sel_status2 = i_bus.addr == `TSC_ADDR_STATUS2;
    assign sel_mask1 = i_bus.addr == `TSC_ADDR_MASK1;
    assign sel_mask2 = i_bus.addr == `TSC_ADDR_MASK2;
    assign wr_mask1 = i_bus.wr && sel_mask1;
    assign wr_mask2 = i_bus.wr && sel_mask2;
    assign rd_status2 = i_bus.rd && sel_status2;

    // ======================================================================
    // One second and short period timers
    localparam int FW = 14;
    localparam logic [FW-1:0] SEC_SHORT_M1 = FW'(SEC_SHORT_FRAMES - 1);
    localparam logic [FW-1:0] SEC_LONG_M1 = FW'(SEC_LONG_FRAMES - 1);
    localparam logic [FW-1:0] SHORT_M1 = FW'(SHORT_FRAMES - 1);

    tsc_phase_t phase_r;
    tsc_phase_t phase_nxt;
    logic [FW-1:0] sec_cnt_r;
    logic [FW-1:0] sec_lim;
    logic [FW-1:0] short_cnt_r;
    logic sec_tick;
    logic short_tick;
    logic snap;

    assign sec_lim = (phase_r == TSC_PH_C) ? SEC_LONG_M1 : SEC_SHORT_M1;
    assign sec_tick = i_frame_tick && (sec_cnt_r == sec_lim);
    assign short_tick = i_frame_tick && (short_cnt_r == SHORT_M1);
    assign snap = i_counter_period_select ? short_tick : sec_tick;

    always_comb begin
        unique case (phase_r)
            TSC_PH_A: phase_nxt = TSC_PH_B;
            TSC_PH_B: phase_nxt = TSC_PH_C;
            TSC_PH_C: phase_nxt = TSC_PH_A;
            default: phase_nxt = TSC_PH_A;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_r <= TSC_PH_A;
            sec_cnt_r <= '0;
            short_cnt_r <= '0;
        end else if (i_frame_tick) begin
            sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + FW'(1);
            short_cnt_r <= short_tick ? '0 : short_cnt_r + FW'(1);
            if (sec_tick) begin
                phase_r <= phase_nxt;
            end
        end
    end

    // ======================================================================
    // Link match, abort and signaling change detection
    logic link_match;
    logic [3:0] ones_r;
    logic abort_hit;
    logic [SIG_W-1:0] sig_r;
    logic sig_seen_r;
    logic sig_change;

    assign link_match = i_link_byte_vld &&
        (i_link_byte == i_link_match_pattern_a ||
         i_link_byte == i_link_match_pattern_b);
    assign abort_hit = i_fdl_bit_vld && i_fdl_bit &&
        (ones_r == `TSC_ABORT_ONES - 4'd1);
    assign sig_change = i_sig_vld && sig_seen_r && (i_sig_bits != sig_r);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ones_r <= '0;
            sig_r <= '0;
            sig_seen_r <= 1'b0;
        end else begin
            if (i_fdl_bit_vld) begin
                ones_r <= (!i_fdl_bit || abort_hit) ? 4'd0 : ones_r + 4'd1;
            end
            if (i_sig_vld) begin
                sig_r <= i_sig_bits;
                sig_seen_r <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Status two: hardware set wins over clear on read
    logic [7:0] status_r;
    logic [7:0] status_set;
    logic [7:0] status_clr;

    assign status_set = {i_rx_mf,
                         i_tx_mf,
                         sec_tick,
                         i_rx_link_full,
                         i_tx_link_empty,
                         link_match,
                         abort_hit,
                         sig_change};
    assign status_clr = rd_status2 ? status_r : 8'h00;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_r <= `TSC_STATUS_RST;
        end else begin
            status_r <= (status_r & ~status_clr) | status_set;
        end
    end

    // ======================================================================
    // Mask registers
    logic [7:0] mask1_r;
    logic [7:0] mask2_r;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask1_r <= `TSC_MASK_RST;
            mask2_r <= `TSC_MASK_RST;
        end else begin
            if (wr_mask1) begin
                mask1_r <= i_bus.wdata;
            end
            if (wr_mask2) begin
                mask2_r <= i_bus.wdata;
            end
        end
    end

    // ======================================================================
    // Interrupt output
    logic int_nxt;

    assign int_nxt = |(status_r & mask2_r) ||
                     |(i_alarm_status & mask1_r);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_int <= 1'b0;
        end else begin
            o_int <= int_nxt;
        end
    end

    // ======================================================================
    // Line code violation qualification
    logic [4:0] zero_run_r;
    logic [4:0] zero_lim;
    logic zero_hit;
    logic bpv_cnt;
    logic lcv_inc;

    assign zero_lim = i_rx_zero_sub_enable ? `TSC_ZERO_RUN_SHORT :
                      `TSC_ZERO_RUN_LONG;
    assign zero_hit = i_line.vld && i_line.zero && i_excess_zero_en &&
                      (zero_run_r == zero_lim - 5'd1);
    assign bpv_cnt = i_line.vld && i_line.bpv &&
                     !(i_rx_zero_sub_enable && i_line.sub_word);
    assign lcv_inc = bpv_cnt || zero_hit;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            zero_run_r <= '0;
        end else if (i_line.vld) begin
            zero_run_r <= (!i_line.zero || zero_hit) ? 5'd0 :
                          (zero_run_r == 5'd31) ? zero_run_r :
                          zero_run_r + 5'd1;
        end
    end

    // ======================================================================
    // Path violation qualification
    logic pcv_inc;
    logic pcv_raw;

    assign pcv_raw = i_rx_framing_select ? i_path.crc_err :
        (i_path.ft_err || (i_fs_error_count_enable && i_path.fs_err));
    assign pcv_inc = pcv_raw && !i_sync_loss;

    // ======================================================================
    // Error counters
    logic [`TSC_LCV_W-1:0] lcv_val;
    logic [`TSC_PCV_W-1:0] pcv_val;
    logic [`TSC_MOS_W-1:0] mos_val;

    tsc_err_counter #(.W(`TSC_LCV_W)) u_lcv (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_inc(lcv_inc),
        .i_snap(snap),
        .o_value(lcv_val)
    );

    tsc_err_counter #(.W(`TSC_PCV_W)) u_pcv (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_inc(pcv_inc),
        .i_snap(snap),
        .o_value(pcv_val)
    );

    tsc_err_counter #(.W(`TSC_MOS_W)) u_mos (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_inc(i_mos_inc),
        .i_snap(snap),
        .o_value(mos_val)
    );

    // ======================================================================
    // Read data
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = 8'h00;
        unique case (i_bus.addr)
            `TSC_ADDR_STATUS2: rdata_nxt = status_r;
            `TSC_ADDR_LCV_HI: rdata_nxt = lcv_val[15:8];
            `TSC_ADDR_LCV_LO: rdata_nxt = lcv_val[7:0];
            `TSC_ADDR_PCV_HI: rdata_nxt = {mos_val[11:8],
                                           pcv_val[11:8]};
            `TSC_ADDR_PCV_LO: rdata_nxt = pcv_val[7:0];
            `TSC_ADDR_MASK2: rdata_nxt = mask2_r;
            `TSC_ADDR_MASK1: rdata_nxt = mask1_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            o_rdata <= rdata_nxt;
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    a_rx_mf_set: assert property (i_rx_mf |=> status_r[7])
        else $error("rx multiframe bit not set");
    a_tx_mf_set: assert property (i_tx_mf |=> status_r[6])
        else $error("tx multiframe bit not set");
    a_sec_period: assert property (sec_tick |-> sec_cnt_r ==
        ((phase_r == TSC_PH_C) ? SEC_LONG_M1 : SEC_SHORT_M1))
        else $error("second tick at wrong frame count");
    a_sec_phase: assert property (sec_tick && phase_r == TSC_PH_C
        |=> phase_r == TSC_PH_A && status_r[5])
        else $error("second phase did not wrap");
    a_link_full: assert property (i_rx_link_full |=> status_r[4])
        else $error("buffer full bit not set");
    a_link_empty: assert property (i_tx_link_empty |=> status_r[3])
        else $error("buffer empty bit not set");
    a_link_match: assert property (i_link_byte_vld &&
        i_link_byte == i_link_match_pattern_b |=> status_r[2])
        else $error("match bit not set");
    a_abort_ones: assert property (abort_hit |-> ones_r == 4'd7)
        else $error("abort at wrong run length");
    a_sig_change: assert property (sig_change |=> status_r[0])
        else $error("signaling change missed");
    a_mask_write: assert property (wr_mask1
        |=> mask1_r == $past(i_bus.wdata))
        else $error("alarm mask not written");
    a_mask_gate: assert property (status_r[7] && mask2_r[7]
        |=> o_int)
        else $error("enabled status did not interrupt");
    a_int_quiet: assert property (status_r == 8'h00 &&
        mask1_r == 8'h00 |=> !o_int)
        else $error("interrupt without source");
    a_snap_sec: assert property (!i_counter_period_select && snap
        |-> sec_tick)
        else $error("snapshot off second boundary");
    a_path_sync: assert property (i_sync_loss |-> !pcv_inc)
        else $error("path count during sync loss");
    a_line_sync: assert property (i_sync_loss && bpv_cnt
        |-> lcv_inc)
        else $error("line count halted by sync loss");
    a_hold_value: assert property (!snap |=> $stable(lcv_val))
        else $error("line count changed mid interval");

    c_sec_tick: cover property (sec_tick && phase_r == TSC_PH_C);
    c_short_snap: cover property (i_counter_period_select && snap);
    c_read_clear: cover property (rd_status2 && status_r != 8'h00);
    c_interrupt: cover property (o_int);

endmodule // tsc_status_counters

// ==== testbench/tsc_host_model.sv ====
module tsc_host_model (
    input wire logic i_ref_clk,
    output tsc_pkg::tsc_bus_t o_bus
);
    timeunit 1ns;
    timeprecision 100ps;
    import tsc_pkg::*;

    // ======================================================================
    // Expected read data, address in the high byte, oldest first
    logic [15:0] exp_q[$];

    initial o_bus = '0;

    // ======================================================================
    // One strobe cycle, then strobes cleared and address and data lines released to inverted values
    task automatic req(input logic w, input logic [7:0] a,
            input logic [7:0] d);
        @(posedge i_ref_clk);
        #2;
        o_bus = {a, w, ~w, d};
        @(posedge i_ref_clk);
        #2;
        o_bus = {~a, 2'h0, ~d};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        req(1'b0, a, ~e);
    endtask
endmodule // tsc_host_model

// ==== testbench/tb.sv ====
`include "tsc_cfg.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tsc_pkg::*;

    // ======================================================================
    // Stimulus and bookkeeping
    localparam int FT = 4;
    localparam int SS = 6;
    localparam int SL = 8;
    localparam int SH = 3;
    localparam logic [7:0] ADDRS [12] = '{8'h21, 8'h23, 8'h24, 8'h25,
        8'h26, 8'h6f, 8'h7f, 8'h20, 8'h22, 8'h27, 8'h00, 8'hff};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    tsc_bus_t bus;
    logic [7:0] rdata;
    logic irq;
    logic ftick = 1'b0;
    logic [7:0] ev = '0;
    logic [7:0] lbyte = '0;
    logic [7:0] pa = '0;
    logic [7:0] pb = '0;
    logic fbit = 1'b0;
    logic [23:0] sig = '0;
    logic [7:0] alarm = '0;
    tsc_line_t ln = '0;
    tsc_path_t pt = '0;
    logic [5:0] cfg = '0;
    logic mos = 1'b0;
    logic rd_q = 1'b0;
    logic [1:0] ftc = '0;
    logic [31:0] seed = 32'h0000dd1b;
    int tick_left = 0;
    int cyc = 0;
    int t_rise = 0;
    int n_fail = 0;
    int n_tests = 0;

    tsc_host_model i_host (
        .i_ref_clk(clk),
        .o_bus(bus)
    );

    tsc_status_counters #(
        .SEC_SHORT_FRAMES(SS),
        .SEC_LONG_FRAMES(SL),
        .SHORT_FRAMES(SH)
    ) i_dut (
        .i_ref_clk(clk),
        .i_nrst(nrst),
        .i_bus(bus),
        .o_rdata(rdata),
        .o_int(irq),
        .i_frame_tick(ftick),
        .i_rx_mf(ev[7]),
        .i_tx_mf(ev[6]),
        .i_rx_link_full(ev[4]),
        .i_tx_link_empty(ev[3]),
        .i_link_byte_vld(ev[2]),
        .i_link_byte(lbyte),
        .i_link_match_pattern_a(pa),
        .i_link_match_pattern_b(pb),
        .i_fdl_bit_vld(ev[1]),
        .i_fdl_bit(fbit),
        .i_sig_vld(ev[0]),
        .i_sig_bits(sig),
        .i_alarm_status(alarm),
        .i_line(ln),
        .i_excess_zero_en(cfg[4]),
        .i_rx_zero_sub_enable(cfg[3]),
        .i_path(pt),
        .i_rx_framing_select(cfg[2]),
        .i_fs_error_count_enable(cfg[1]),
        .i_sync_loss(cfg[0]),
        .i_counter_period_select(cfg[5]),
        .i_mos_inc(mos)
    );

    // ======================================================================
    // Clock, frame ticks, timeout, read monitor
    initial begin
        forever begin
            #25 clk = ~clk;
        end
    end

    initial begin
        forever begin
            @(posedge clk);
            #2;
            ftc = ftc + 2'h1;
            ftick = (ftc == 2'h0) && (tick_left > 0);
            if (ftick) begin
                tick_left = tick_left - 1;
            end
        end
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_q <= bus.rd;
        if (cyc > 90000) begin
            n_fail++;
            wrap_up();
        end
    end

    always @(negedge clk) begin
        logic [15:0] e;
        if (rd_q) begin
            e = i_host.exp_q.pop_front();
            check($sformatf("rdata at %h", e[15:8]), rdata, e[7:0]);
        end
    end

    // ======================================================================
    // Helpers
    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wait_int();
        int k;
        k = 0;
        while (irq !== 1'b1) begin
            tick(1);
            k++;
            if (k > 400) begin
                n_fail++;
                wrap_up();
            end
        end
        t_rise = cyc;
        i_host.rd(`TSC_ADDR_STATUS2, 8'h20);
        // Interrupt falls one edge after the clearing read
        tick(1);
    endtask

    task automatic fire(input int b, input logic [7:0] pat);
        lbyte = pat;
        fbit = 1'b1;
        if (b == 0) begin
            sig = sig ^ (24'h1 << (rnd() % 24));
        end
        ev = 8'h01 << b;
        tick((b == 1) ? 8 : 1);
        ev = '0;
    endtask

    task automatic cnt_case(input logic [5:0] c, input tsc_line_t l,
            input tsc_path_t p, input logic m, input int n,
            input logic [15:0] el, input logic [11:0] ep,
            input logic [3:0] em);
        cfg = c;
        tick_left = 1000000;
        wait_int();
        tick_left = 0;
        ln = l;
        pt = p;
        mos = m;
        tick(n);
        ln = 4'h8;
        pt = '0;
        mos = 1'b0;
        tick(1);
        ln = '0;
        tick_left = c[5] ? SH : 1000000;
        if (c[5]) begin
            tick(FT * SH + 4);
        end else begin
            wait_int();
        end
        i_host.rd(`TSC_ADDR_LCV_HI, el[15:8]);
        i_host.rd(`TSC_ADDR_LCV_LO, el[7:0]);
        i_host.rd(`TSC_ADDR_PCV_HI, {em, ep[11:8]});
        i_host.rd(`TSC_ADDR_PCV_LO, ep[7:0]);
    endtask

    // ======================================================================
    // Main sequence
    initial begin : main
        int b;
        int p;
        int k;
        int t0;
        logic [7:0] m;
        repeat (5) @(posedge clk);
        #2;
        nrst = 1'b1;
        foreach (ADDRS[i]) begin
            i_host.rd(ADDRS[i], 8'h00);
        end
        i_host.wr(`TSC_ADDR_LCV_HI, 8'hff);
        i_host.rd(`TSC_ADDR_LCV_HI, 8'h00);
        m = 8'(rnd());
        i_host.wr(`TSC_ADDR_MASK1, m);
        i_host.rd(`TSC_ADDR_MASK1, m);
        m = 8'(rnd());
        i_host.wr(`TSC_ADDR_MASK2, m);
        i_host.rd(`TSC_ADDR_MASK2, m);
        i_host.wr(`TSC_ADDR_MASK2, 8'h20);
        tick_left = 1000000;
        wait_int();
        t0 = t_rise;
        for (k = 0; k < 3; k++) begin
            wait_int();
            check("sec gap", t_rise - t0, FT * ((k == 1) ? SL : SS));
            t0 = t_rise;
        end
        cnt_case(6'h00, 4'ha, 3'h4, 0, 5, 16'h5, 12'h0, 4'h0);
        cnt_case(6'h08, 4'hb, 3'h0, 0, 5, 16'h0, 12'h0, 4'h0);
        cnt_case(6'h08, 4'ha, 3'h0, 0, 3, 16'h3, 12'h0, 4'h0);
        cnt_case(6'h00, 4'hc, 3'h0, 0, 16, 16'h0, 12'h0, 4'h0);
        cnt_case(6'h10, 4'hc, 3'h0, 0, 16, 16'h1, 12'h0, 4'h0);
        cnt_case(6'h18, 4'hc, 3'h0, 0, 16, 16'h2, 12'h0, 4'h0);
        cnt_case(6'h04, 4'h0, 3'h4, 0, 7, 16'h0, 12'h7, 4'h0);
        cnt_case(6'h06, 4'h0, 3'h3, 0, 3, 16'h0, 12'h0, 4'h0);
        cnt_case(6'h00, 4'h0, 3'h3, 0, 4, 16'h0, 12'h4, 4'h0);
        cnt_case(6'h02, 4'h0, 3'h1, 0, 3, 16'h0, 12'h3, 4'h0);
        cnt_case(6'h05, 4'ha, 3'h4, 0, 6, 16'h6, 12'h0, 4'h0);
        cnt_case(6'h20, 4'ha, 3'h0, 0, 9, 16'h9, 12'h0, 4'h0);
        cnt_case(6'h04, 4'ha, 3'h4, 1, 65540, 16'hffff, 12'hfff,
            4'hf);
        tick_left = 0;
        pa = 8'(rnd());
        pb = pa ^ 8'h5a;
        for (p = 0; p < 2; p++) begin
            for (b = 0; b < 8; b++) begin
                if (b != 5) begin
                    m = 8'h01 << b;
                    m = ((b + p) % 2 == 0) ? m : ~m;
                    i_host.wr(`TSC_ADDR_MASK2, m);
                    lbyte = pa ^ 8'h01;
                    for (k = 0; k < 8; k++) begin
                        fbit = (k != 7);
                        ev = 8'h07;
                        tick(1);
                    end
                    ev = '0;
                    i_host.rd(`TSC_ADDR_STATUS2, 8'h00);
                    fire(b, p ? pb : pa);
                    tick(3);
                    check("irq", irq, (b + p) % 2 == 0);
                    m = 8'h01 << b;
                    i_host.rd(`TSC_ADDR_STATUS2, m);
                    tick(2);
                    check("irq", irq, 0);
                end
            end
        end
        i_host.wr(`TSC_ADDR_MASK2, 8'h00);
        for (b = 0; b < 8; b++) begin
            alarm = 8'h01 << b;
            i_host.wr(`TSC_ADDR_MASK1, alarm);
            tick(2);
            check("irq", irq, 1);
            i_host.wr(`TSC_ADDR_MASK1, ~alarm);
            tick(2);
            check("irq", irq, 0);
        end
        alarm = '0;
        wrap_up();
    end
endmodule // tb
